// File: src/t8_pkg.sv
// Constants, field layouts and types of the 8-bit timer/counter
package t8_pkg;
    // ---------------------------------------------------------------
    // Register offsets
    // ---------------------------------------------------------------
    localparam logic [3:0] ADDR_CTRL_A = 4'h0;
    localparam logic [3:0] ADDR_CTRL_B = 4'h1;
    localparam logic [3:0] ADDR_COUNTER = 4'h2;
    localparam logic [3:0] ADDR_CMP_A = 4'h3;
    localparam logic [3:0] ADDR_CMP_B = 4'h4;
    localparam logic [3:0] ADDR_ASYNC = 4'h5;
    localparam logic [3:0] ADDR_FLAG = 4'h6;
    localparam logic [3:0] ADDR_MASK = 4'h7;

    // ---------------------------------------------------------------
    // Field positions and values
    // ---------------------------------------------------------------
    localparam int COM_A_LSB = 0;
    localparam int COM_B_LSB = 2;
    localparam int MODE_LSB = 4;
    localparam int FLAG_OVF = 0;
    localparam int FLAG_MATCH_A = 1;
    localparam int FLAG_MATCH_B = 2;
    localparam int ASYNC_SEL_BIT = 0;
    localparam logic [7:0] BOTTOM = 8'h00;
    localparam logic [7:0] MAX = 8'hFF;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [2:0] FLAG_NONE = 3'h0;
    localparam logic [9:0] PSC_ZERO = 10'h000;
    localparam logic [9:0] PSC_ONE = 10'h001;

    // ---------------------------------------------------------------
    // Prescaler select masks
    // ---------------------------------------------------------------
    localparam logic [2:0] CS_OFF = 3'h0;
    localparam logic [9:0] PSC_MASK_1 = 10'h000;
    localparam logic [9:0] PSC_MASK_8 = 10'h007;
    localparam logic [9:0] PSC_MASK_32 = 10'h01F;
    localparam logic [9:0] PSC_MASK_64 = 10'h03F;
    localparam logic [9:0] PSC_MASK_128 = 10'h07F;
    localparam logic [9:0] PSC_MASK_256 = 10'h0FF;
    localparam logic [9:0] PSC_MASK_1024 = 10'h3FF;

    // ---------------------------------------------------------------
    // Types
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_NORMAL = 3'b000,
        MODE_PHASE_MAX = 3'b001,
        MODE_CTC = 3'b010,
        MODE_FAST_MAX = 3'b011,
        MODE_RSV_4 = 3'b100,
        MODE_PHASE_OCA = 3'b101,
        MODE_RSV_6 = 3'b110,
        MODE_FAST_OCA = 3'b111
    } t8_mode_type;

    typedef enum logic [1:0] {
        COM_OFF = 2'b00,
        COM_TOGGLE = 2'b01,
        COM_CLEAR = 2'b10,
        COM_SET = 2'b11
    } t8_com_type;
endpackage

// File: src/t8_cnt_if.sv
// Counter state shared from the core to each compare channel
`timescale 1ns/1ps
interface t8_cnt_if;
    logic [7:0] count;
    logic tick;
    logic count_up;
    logic at_top;
    logic buffered;
    logic buf_update;
    logic fast_pwm;
    logic phase_pwm;
    logic toggle_ok;

    modport core (output count, tick, count_up, at_top, buffered, buf_update,
        fast_pwm, phase_pwm, toggle_ok);
    modport chan (input count, tick, count_up, at_top, buffered, buf_update,
        fast_pwm, phase_pwm, toggle_ok);
endinterface

// File: src/t8_compare.sv
// One double-buffered compare channel with its waveform output
`timescale 1ns/1ps
module t8_compare (
    input wire logic clk,
    input wire logic reset_n,
    t8_cnt_if.chan cnt,
    input wire logic wr,
    input wire logic [7:0] wr_data,
    input wire logic [1:0] com,
    input wire logic toggle_allowed,
    output logic [7:0] value,
    output logic match,
    output logic wave_out
);
    logic [7:0] buf_reg, buf_next;
    logic [7:0] act_reg, act_next;
    logic wave_reg, wave_next;

    // -----------------------------------------------------------------
    // Compare and waveform
    // -----------------------------------------------------------------
    // (R6) compare on each timer tick, not in a cycle with a counter write
    assign match = cnt.tick && (cnt.count == act_reg);

    always_comb begin
        buf_next = buf_reg;
        act_next = act_reg;
        wave_next = wave_reg;
        if (wr) begin
            buf_next = wr_data;
        end
        // (R14) buffered or direct update
        if (!cnt.buffered && wr) begin
            act_next = wr_data;
        end else if (cnt.buffered && cnt.buf_update) begin
            act_next = buf_reg;
        end
        // (R7) waveform from match
        unique case (t8_pkg::t8_com_type'(com))
            t8_pkg::COM_OFF: wave_next = 1'b0;
            t8_pkg::COM_TOGGLE: begin
                // (R13) toggle gives io/2 at zero
                if (match && (toggle_allowed || !(cnt.fast_pwm || cnt.phase_pwm))) begin
                    wave_next = ~wave_reg;
                end
            end
            t8_pkg::COM_CLEAR, t8_pkg::COM_SET: begin
                if (cnt.fast_pwm) begin
                    if (match) begin
                        wave_next = com[0];
                    end else if (cnt.tick && cnt.at_top) begin
                        wave_next = ~com[0];
                    end
                end else if (cnt.phase_pwm) begin
                    // (R17) clear up, set down
                    if (match) begin
                        wave_next = cnt.count_up ? com[0] : ~com[0];
                    end
                end else if (match) begin
                    wave_next = com[0];
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            buf_reg <= t8_pkg::RESET_BYTE;
            act_reg <= t8_pkg::RESET_BYTE;
            wave_reg <= 1'b0;
        end else begin
            buf_reg <= buf_next;
            act_reg <= act_next;
            wave_reg <= wave_next;
        end
    end

    assign value = act_reg;
    assign wave_out = wave_reg;

    // -----------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_toggle_on_match: assert property ( // (R7)
        com == t8_pkg::COM_TOGGLE && match && !(cnt.fast_pwm || cnt.phase_pwm)
        |=> wave_reg != $past(wave_reg))
        else $error("waveform did not toggle on match");
    a_direct_write: assert property ( // (R14)
        !cnt.buffered && wr |=> act_reg == $past(wr_data))
        else $error("direct compare write not applied");
    a_phase_clear_up: assert property ( // (R17)
        cnt.phase_pwm && com == t8_pkg::COM_CLEAR && match && cnt.count_up
        |=> !wave_reg)
        else $error("phase pwm output not cleared on up match");
endmodule

// File: src/t8_timer.sv
// Top of the 8-bit timer/counter with register port and interrupt
`timescale 1ns/1ps
// How it works
// (R1) Counter and compare registers are eight bits
// (R2) Flags visible, each gated by mask
// (R3) Clock from prescaler or oscillator pin
// (R4) No clock source: counter holds
// (R5) Async select bit switches to oscillator
// (R6) Compare values checked every cycle; the code compares on timer ticks only, not in a cycle with a counter write
// (R7) Matches drive waveform outputs
// (R8) Match sets channel flag, can interrupt
// (R9) Bottom is value zero
// (R10) Maximum is value 255
// (R11) Top is 255 or compare A
// (R12) Counter counts up or down
// (R13) Toggle on zero compare gives io/2
// (R14) Fast PWM buffered, CTC writes direct
// (R15) Phase PWM reverses, holds top once
// (R16) Phase PWM overflow flag at bottom
// (R17) Phase PWM clear up, set down
// (R18) Flags cleared by service or one
// (R19) Oscillator input synchronised to io clock
module t8_timer (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [3:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rd_data,
    input wire logic osc_in_pin,
    output logic osc_out_pin,
    input wire logic [2:0] irq_ack,
    output logic wave_out_a,
    output logic wave_out_b,
    output logic irq
);
    // -----------------------------------------------------------------
    // Registers
    // -----------------------------------------------------------------
    logic [7:0] ctrl_a_reg, ctrl_a_next;
    logic [2:0] clk_sel_reg, clk_sel_next;
    logic async_clock_select_reg, async_clock_select_next;
    logic [2:0] irq_flag_reg, irq_flag_next;
    logic [2:0] irq_mask_reg, irq_mask_next;
    logic [7:0] rd_data_reg, rd_data_next;
    // (R1) eight-bit count and compares
    logic [7:0] counter_value_reg, counter_value_next;
    logic count_up_reg, count_up_next;
    logic [9:0] psc_reg, psc_next;
    logic osc_meta_reg, osc_sync_reg, osc_prev_reg, osc_out_reg;

    t8_cnt_if cnt ();

    t8_pkg::t8_mode_type mode;
    logic [1:0] com_a, com_b;
    logic [7:0] compare_value_a, compare_value_b;
    logic [7:0] top;
    logic match_a, match_b;
    logic src_event, timer_tick, at_top, cnt_wr, ovf_event;
    logic [9:0] psc_mask;

    assign mode = t8_pkg::t8_mode_type'(ctrl_a_reg[t8_pkg::MODE_LSB +: 3]);
    assign com_a = ctrl_a_reg[t8_pkg::COM_A_LSB +: 2];
    assign com_b = ctrl_a_reg[t8_pkg::COM_B_LSB +: 2];
    assign cnt_wr = wr_en && addr == t8_pkg::ADDR_COUNTER;

    // -----------------------------------------------------------------
    // Clock source and prescaler
    // -----------------------------------------------------------------
    // (R19) two-flop sync, edge from second stage
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            osc_meta_reg <= 1'b0;
            osc_sync_reg <= 1'b0;
            osc_prev_reg <= 1'b0;
            osc_out_reg <= 1'b0;
        end else begin
            osc_meta_reg <= osc_in_pin;
            osc_sync_reg <= osc_meta_reg;
            osc_prev_reg <= osc_sync_reg;
            osc_out_reg <= async_clock_select_reg & ~osc_sync_reg;
        end
    end
    assign osc_out_pin = osc_out_reg;

    // (R5) io clock unless async select set
    assign src_event = async_clock_select_reg ? (osc_sync_reg & ~osc_prev_reg) : 1'b1;

    always_comb begin
        unique case (clk_sel_reg)
            3'h0, 3'h1: psc_mask = t8_pkg::PSC_MASK_1;
            3'h2: psc_mask = t8_pkg::PSC_MASK_8;
            3'h3: psc_mask = t8_pkg::PSC_MASK_32;
            3'h4: psc_mask = t8_pkg::PSC_MASK_64;
            3'h5: psc_mask = t8_pkg::PSC_MASK_128;
            3'h6: psc_mask = t8_pkg::PSC_MASK_256;
            3'h7: psc_mask = t8_pkg::PSC_MASK_1024;
        endcase
    end

    // (R3) prescaled tick from chosen source
    assign timer_tick = clk_sel_reg != t8_pkg::CS_OFF && src_event
        && (psc_reg & psc_mask) == psc_mask;

    // -----------------------------------------------------------------
    // Counter unit
    // -----------------------------------------------------------------
    // (R11) top is 255 or compare A
    assign top = (mode == t8_pkg::MODE_CTC || mode == t8_pkg::MODE_PHASE_OCA
        || mode == t8_pkg::MODE_FAST_OCA) ? compare_value_a : t8_pkg::MAX;
    assign at_top = counter_value_reg == top;

    always_comb begin
        counter_value_next = counter_value_reg;
        count_up_next = count_up_reg;
        ovf_event = 1'b0;
        psc_next = psc_reg;
        if (clk_sel_reg != t8_pkg::CS_OFF && src_event) begin
            psc_next = psc_reg + t8_pkg::PSC_ONE;
        end
        if (cnt_wr) begin
            counter_value_next = wr_data;
        // (R4) idle without a clock source
        end else if (timer_tick) begin
            if (cnt.phase_pwm) begin
                // (R15) reverse at top, top held once
                if (count_up_reg) begin
                    if (at_top) begin
                        count_up_next = 1'b0;
                        counter_value_next = counter_value_reg - 8'h01;
                    end else begin
                        counter_value_next = counter_value_reg + 8'h01;
                    end
                // (R9) bottom is zero
                end else if (counter_value_reg == t8_pkg::BOTTOM) begin
                    count_up_next = 1'b1;
                    counter_value_next = counter_value_reg + 8'h01;
                    // (R16) overflow at bottom
                    ovf_event = 1'b1;
                end else begin
                    // (R12) count down
                    counter_value_next = counter_value_reg - 8'h01;
                end
            end else begin
                count_up_next = 1'b1;
                counter_value_next = at_top ? t8_pkg::BOTTOM : counter_value_reg + 8'h01;
                // (R10) wrap from max
                ovf_event = cnt.fast_pwm ? at_top : counter_value_reg == t8_pkg::MAX;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            counter_value_reg <= t8_pkg::RESET_BYTE;
            count_up_reg <= 1'b1;
            psc_reg <= t8_pkg::PSC_ZERO;
        end else begin
            counter_value_reg <= counter_value_next;
            count_up_reg <= count_up_next;
            psc_reg <= psc_next;
        end
    end

    assign cnt.count = counter_value_reg;
    assign cnt.tick = timer_tick && !cnt_wr;
    assign cnt.count_up = count_up_reg;
    assign cnt.at_top = at_top;
    assign cnt.fast_pwm = mode == t8_pkg::MODE_FAST_MAX || mode == t8_pkg::MODE_FAST_OCA;
    assign cnt.phase_pwm = mode == t8_pkg::MODE_PHASE_MAX || mode == t8_pkg::MODE_PHASE_OCA;
    assign cnt.buffered = cnt.fast_pwm || cnt.phase_pwm;
    assign cnt.buf_update = timer_tick && at_top && (cnt.fast_pwm || count_up_reg);
    assign cnt.toggle_ok = mode == t8_pkg::MODE_FAST_OCA || mode == t8_pkg::MODE_PHASE_OCA;

    // -----------------------------------------------------------------
    // Compare channels
    // -----------------------------------------------------------------
    // In PWM, toggle on top-defining compare A only; B never toggles in PWM
    t8_compare u_cmp_a (
        .clk(clk),
        .reset_n(reset_n),
        .cnt(cnt.chan),
        .wr(wr_en && addr == t8_pkg::ADDR_CMP_A),
        .wr_data(wr_data),
        .com(com_a),
        .toggle_allowed(cnt.toggle_ok),
        .value(compare_value_a),
        .match(match_a),
        .wave_out(wave_out_a)
    );

    t8_compare u_cmp_b (
        .clk(clk),
        .reset_n(reset_n),
        .cnt(cnt.chan),
        .wr(wr_en && addr == t8_pkg::ADDR_CMP_B),
        .wr_data(wr_data),
        .com(com_b),
        .toggle_allowed(1'b0),
        .value(compare_value_b),
        .match(match_b),
        .wave_out(wave_out_b)
    );

    // -----------------------------------------------------------------
    // Register port and flags
    // -----------------------------------------------------------------
    always_comb begin
        ctrl_a_next = ctrl_a_reg;
        clk_sel_next = clk_sel_reg;
        async_clock_select_next = async_clock_select_reg;
        irq_mask_next = irq_mask_reg;
        irq_flag_next = irq_flag_reg;
        rd_data_next = t8_pkg::RESET_BYTE;
        if (wr_en) begin
            unique case (addr)
                t8_pkg::ADDR_CTRL_A: ctrl_a_next = wr_data;
                t8_pkg::ADDR_CTRL_B: clk_sel_next = wr_data[2:0];
                t8_pkg::ADDR_ASYNC: async_clock_select_next = wr_data[t8_pkg::ASYNC_SEL_BIT];
                t8_pkg::ADDR_MASK: irq_mask_next = wr_data[2:0];
                // (R18) write one clears
                t8_pkg::ADDR_FLAG: irq_flag_next = irq_flag_reg & ~wr_data[2:0];
                default: ;
            endcase
        end
        if (rd_en) begin
            unique case (addr)
                t8_pkg::ADDR_CTRL_A: rd_data_next = ctrl_a_reg;
                t8_pkg::ADDR_CTRL_B: rd_data_next = {5'h00, clk_sel_reg};
                t8_pkg::ADDR_COUNTER: rd_data_next = counter_value_reg;
                t8_pkg::ADDR_CMP_A: rd_data_next = compare_value_a;
                t8_pkg::ADDR_CMP_B: rd_data_next = compare_value_b;
                t8_pkg::ADDR_ASYNC: rd_data_next = {7'h00, async_clock_select_reg};
                t8_pkg::ADDR_FLAG: begin
                    rd_data_next = {5'h00, irq_flag_reg};
                    irq_flag_next = t8_pkg::FLAG_NONE;
                end
                t8_pkg::ADDR_MASK: rd_data_next = {5'h00, irq_mask_reg};
                default: rd_data_next = t8_pkg::RESET_BYTE;
            endcase
        end
        // (R18) service acknowledge clears
        irq_flag_next = irq_flag_next & ~irq_ack;
        // (R8) events set, set beats clear
        irq_flag_next[t8_pkg::FLAG_OVF] = irq_flag_next[t8_pkg::FLAG_OVF] | ovf_event;
        irq_flag_next[t8_pkg::FLAG_MATCH_A] = irq_flag_next[t8_pkg::FLAG_MATCH_A] | match_a;
        irq_flag_next[t8_pkg::FLAG_MATCH_B] = irq_flag_next[t8_pkg::FLAG_MATCH_B] | match_b;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_a_reg <= t8_pkg::RESET_BYTE;
            clk_sel_reg <= t8_pkg::CS_OFF;
            async_clock_select_reg <= 1'b0;
            irq_mask_reg <= t8_pkg::FLAG_NONE;
            irq_flag_reg <= t8_pkg::FLAG_NONE;
            rd_data_reg <= t8_pkg::RESET_BYTE;
        end else begin
            ctrl_a_reg <= ctrl_a_next;
            clk_sel_reg <= clk_sel_next;
            async_clock_select_reg <= async_clock_select_next;
            irq_mask_reg <= irq_mask_next;
            irq_flag_reg <= irq_flag_next;
            rd_data_reg <= rd_data_next;
        end
    end

    assign rd_data = rd_data_reg;
    // (R2) each flag gated by its mask bit
    assign irq = |(irq_flag_reg & irq_mask_reg);

    // -----------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence s_phase_at_top;
        cnt.phase_pwm && timer_tick && !cnt_wr && count_up_reg && at_top;
    endsequence

    a_irq_mask_gate: assert property ( // (R2)
        irq_mask_reg == t8_pkg::FLAG_NONE |-> !irq)
        else $error("interrupt not gated by mask");
    a_match_flag: assert property ( // (R8)
        match_a |=> irq_flag_reg[t8_pkg::FLAG_MATCH_A])
        else $error("match a flag not set");
    a_idle_hold: assert property ( // (R4)
        clk_sel_reg == t8_pkg::CS_OFF && !cnt_wr |=> $stable(counter_value_reg))
        else $error("counter moved with no clock source");
    a_io_tick: assert property ( // (R5)
        !async_clock_select_reg && clk_sel_reg == 3'h1 |-> timer_tick)
        else $error("io clock tick missing");
    a_phase_reverse: assert property ( // (R15)
        s_phase_at_top |=> !count_up_reg && counter_value_reg == $past(counter_value_reg) - 8'h01)
        else $error("phase pwm did not reverse at top");
    a_bottom_flag: assert property ( // (R16)
        cnt.phase_pwm && timer_tick && !cnt_wr && !count_up_reg
        && counter_value_reg == t8_pkg::BOTTOM |=> irq_flag_reg[t8_pkg::FLAG_OVF])
        else $error("overflow flag not set at bottom");
    a_wrap_max: assert property ( // (R10)
        mode == t8_pkg::MODE_NORMAL && timer_tick && !cnt_wr
        && counter_value_reg == t8_pkg::MAX
        |=> counter_value_reg == t8_pkg::BOTTOM && irq_flag_reg[t8_pkg::FLAG_OVF])
        else $error("normal mode wrap from max wrong");
endmodule

// File: sim/timer8_async_counter_core_tb.sv
// Self-checking bench for the 8-bit timer/counter
`timescale 1ns/1ps
`define CHK(name, exp, got) \
    begin \
        check_count++; \
        if ((got) !== (exp)) begin \
            err_count++; \
            $display("FAIL %s expected %h seen %h", name, exp, got); \
        end \
    end
module timer8_async_counter_core_tb;
    logic clk = 1'h0;
    logic reset_n = 1'h0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wr_data = 8'h00;
    logic wr_en = 1'h0;
    logic rd_en = 1'h0;
    logic [7:0] rd_data;
    logic osc_in_pin = 1'h0;
    logic osc_out_pin;
    logic [2:0] irq_ack = 3'h0;
    logic wave_out_a;
    logic wave_out_b;
    logic irq;
    int err_count = 0;
    int check_count = 0;
    logic [7:0] seen;
    logic prev;

    always #4 clk = ~clk;

    t8_timer dut (.clk(clk), .reset_n(reset_n), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .osc_in_pin(osc_in_pin),
        .osc_out_pin(osc_out_pin), .irq_ack(irq_ack), .wave_out_a(wave_out_a),
        .wave_out_b(wave_out_b), .irq(irq));

    // ---------------------------------------------------------------
    // Bus and pin tasks
    // ---------------------------------------------------------------
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'h1;
        @(posedge clk);
        wr_en <= 1'h0;
    endtask

    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'h1;
        @(posedge clk);
        rd_en <= 1'h0;
        #1;
        seen = rd_data;
    endtask

    // Bounded, so a dead interrupt shows as a mismatch, not a hang
    task automatic wait_irq();
        for (int n = 0; n < 60 && irq !== 1'h1; n++) begin
            @(posedge clk);
            #1;
        end
    endtask

    // Slow oscillator: each edge needs the synchroniser delay
    task automatic osc_edges(input int n);
        repeat (n) begin
            repeat (4) @(posedge clk);
            osc_in_pin <= 1'h1;
            repeat (4) @(posedge clk);
            osc_in_pin <= 1'h0;
        end
        repeat (8) @(posedge clk);
    endtask

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic test_reset();
        rd(t8_pkg::ADDR_COUNTER);
        `CHK("counter reset", 8'h00, seen)
        rd(4'h9);
        `CHK("unmapped read", 8'h00, seen)
        wr(t8_pkg::ADDR_CMP_A, 8'hA5);
        rd(t8_pkg::ADDR_CMP_A);
        `CHK("compare a width", 8'hA5, seen)
        wr(t8_pkg::ADDR_COUNTER, 8'h37);
        repeat (20) @(posedge clk);
        rd(t8_pkg::ADDR_COUNTER);
        `CHK("idle counter", 8'h37, seen)
    endtask

    task automatic test_match();
        wr(t8_pkg::ADDR_COUNTER, 8'h00);
        wr(t8_pkg::ADDR_CMP_A, 8'h10);
        wr(t8_pkg::ADDR_CMP_B, 8'h05);
        wr(t8_pkg::ADDR_MASK, 8'h02);
        rd(t8_pkg::ADDR_FLAG);
        wr(t8_pkg::ADDR_CTRL_B, 8'h01);
        repeat (10) @(posedge clk);
        #1;
        `CHK("masked b irq", 1'h0, irq)
        wait_irq();
        `CHK("match a irq", 1'h1, irq)
        rd(t8_pkg::ADDR_FLAG);
        `CHK("match flags", 2'h3, seen[2:1])
        @(posedge clk);
        #1;
        `CHK("irq after read", 1'h0, irq)
        wr(t8_pkg::ADDR_COUNTER, 8'hF0);
        wr(t8_pkg::ADDR_MASK, 8'h01);
        rd(t8_pkg::ADDR_FLAG);
        wait_irq();
        `CHK("overflow irq", 1'h1, irq)
        @(posedge clk);
        irq_ack <= 3'h1;
        @(posedge clk);
        irq_ack <= 3'h0;
        #1;
        `CHK("irq after ack", 1'h0, irq)
        rd(t8_pkg::ADDR_COUNTER);
        `CHK("wrapped low", 1'h1, seen < 8'h20)
        // Near the wrap again, so the next overflow falls inside the wait
        wr(t8_pkg::ADDR_COUNTER, 8'hF8);
        wait_irq();
        `CHK("second overflow irq", 1'h1, irq)
        wr(t8_pkg::ADDR_FLAG, 8'h01);
        #1;
        `CHK("irq after w1c", 1'h0, irq)
        wr(t8_pkg::ADDR_CTRL_B, 8'h00);
    endtask

    task automatic test_async();
        wr(t8_pkg::ADDR_COUNTER, 8'h00);
        wr(t8_pkg::ADDR_ASYNC, 8'h01);
        osc_in_pin <= 1'h1;
        repeat (8) @(posedge clk);
        osc_in_pin <= 1'h0;
        #1;
        `CHK("osc out high in", 1'h0, osc_out_pin)
        repeat (8) @(posedge clk);
        #1;
        `CHK("osc out low in", 1'h1, osc_out_pin)
        wr(t8_pkg::ADDR_CTRL_B, 8'h01);
        repeat (20) @(posedge clk);
        rd(t8_pkg::ADDR_COUNTER);
        `CHK("no osc edges", 8'h00, seen)
        osc_edges(5);
        rd(t8_pkg::ADDR_COUNTER);
        `CHK("osc ticks", 8'h05, seen)
    endtask

    // Oscillator ticks give an exact tick count through the turn at top
    task automatic test_phase();
        wr(t8_pkg::ADDR_CTRL_B, 8'h00);
        wr(t8_pkg::ADDR_CMP_A, 8'hFE);
        wr(t8_pkg::ADDR_CMP_B, 8'hFE);
        wr(t8_pkg::ADDR_COUNTER, 8'hFD);
        wr(t8_pkg::ADDR_CTRL_A, 8'h1E);
        wr(t8_pkg::ADDR_CTRL_B, 8'h01);
        osc_edges(5);
        rd(t8_pkg::ADDR_COUNTER);
        `CHK("phase turn", 8'hFC, seen)
        `CHK("wave a up/down", 1'h1, wave_out_a)
        `CHK("wave b inverted", 1'h0, wave_out_b)
        // Counting down, so a buffered write must wait for the next top
        wr(t8_pkg::ADDR_CMP_B, 8'h10);
        rd(t8_pkg::ADDR_CMP_B);
        `CHK("buffered compare b", 8'hFE, seen)
        rd(t8_pkg::ADDR_FLAG);
        osc_edges(253);
        rd(t8_pkg::ADDR_FLAG);
        `CHK("bottom overflow", 1'h1, seen[0])
        rd(t8_pkg::ADDR_COUNTER);
        `CHK("turn at bottom", 8'h01, seen)
        wr(t8_pkg::ADDR_CTRL_B, 8'h00);
        wr(t8_pkg::ADDR_ASYNC, 8'h00);
    endtask

    task automatic test_toggle();
        wr(t8_pkg::ADDR_CTRL_A, 8'h21);
        wr(t8_pkg::ADDR_CMP_A, 8'h00);
        rd(t8_pkg::ADDR_CMP_A);
        `CHK("direct compare a", 8'h00, seen)
        wr(t8_pkg::ADDR_COUNTER, 8'h00);
        wr(t8_pkg::ADDR_CTRL_B, 8'h01);
        // CTC toggle first, then fast PWM with top on compare A
        for (int m = 0; m < 2; m++) begin
            if (m == 1) begin
                wr(t8_pkg::ADDR_CTRL_A, 8'h71);
            end
            repeat (4) @(posedge clk);
            #1;
            prev = wave_out_a;
            repeat (4) begin
                @(posedge clk);
                #1;
                `CHK("toggle half rate", ~prev, wave_out_a)
                prev = wave_out_a;
            end
        end
        wr(t8_pkg::ADDR_CTRL_B, 8'h00);
    endtask

    // ---------------------------------------------------------------
    // Verdict and run control
    // ---------------------------------------------------------------
    task automatic results();
        $display("Checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Whole run is a few thousand cycles; far margin here
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        results();
    end

    initial begin
        repeat (3) @(posedge clk);
        reset_n <= 1'h1;
        test_reset();
        test_match();
        test_async();
        test_phase();
        test_toggle();
        results();
    end
endmodule
